// [fbvp_byte_sel.sv]
`timescale 1ns/10ps
`default_nettype none
module fbvp_byte_sel (
  // Item and position
  input wire fbvp_pkg::fbvp_item_s item,
  input wire fbvp_pkg::fbvp_fmt_e fmt,
  input wire logic [fbvp_pkg::LANE_IDX_W-1:0] lane,
  // Wire byte
  output logic [7:0] byte_out,
  output logic last_lane
);
  import fbvp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Byte order per frame format and item kind
  always_comb begin
    byte_out = 8'h00;
    if (item.kind == KIND_INT16) begin
      last_lane = (lane == LAST_LANE_WORD);
      byte_out = (lane == 2'h0) ? fbvp_lane(item.value, LANE1_LO) : fbvp_lane(item.value, LANE0_LO); // RULE_02
    end else begin
      last_lane = (lane == LAST_LANE_DWORD); // RULE_05
      if (fmt == FMT_BIG) begin
        // Big endian whatever the kind
        case (lane)
          2'h0: byte_out = fbvp_lane(item.value, LANE3_LO); // RULE_03
          2'h1: byte_out = fbvp_lane(item.value, LANE2_LO); // RULE_03
          2'h2: byte_out = fbvp_lane(item.value, LANE1_LO); // RULE_03
          default: byte_out = fbvp_lane(item.value, LANE0_LO); // RULE_03
        endcase
      end else begin
        // Low word first, each word high byte first; floats share it
        case (lane)
          2'h0: byte_out = fbvp_lane(item.value, LANE1_LO); // RULE_01 RULE_02
          2'h1: byte_out = fbvp_lane(item.value, LANE0_LO); // RULE_01 RULE_02
          2'h2: byte_out = fbvp_lane(item.value, LANE3_LO); // RULE_01 RULE_02
          default: byte_out = fbvp_lane(item.value, LANE2_LO); // RULE_01 RULE_02
        endcase
      end
    end
  end

endmodule : fbvp_byte_sel
`default_nettype wire

// [fbvp_end.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [fbvp_item_map.sv]
`timescale 1ns/10ps
`default_nettype none
module fbvp_item_map (
  // Frozen values and selection
  input wire fbvp_pkg::fbvp_values_s vals,
  input wire fbvp_pkg::fbvp_mod_e mod_sel,
  input wire logic [fbvp_pkg::ITEM_IDX_W-1:0] item_idx,
  // Selected item
  output fbvp_pkg::fbvp_item_s item
);
  import fbvp_pkg::*;

  logic [3:0] idx_ext;

  assign idx_ext = {1'b0, item_idx};

  ////////////////////////////////////////////////////////////////////////////
  // Item order inside each module; out of range reads as zero, except thermal, where it reads the capacity float
  always_comb begin
    item.kind = KIND_UINT32;
    item.value = 32'h0000_0000;
    case (mod_sel)
      MOD_ELEC: begin
        item.kind = KIND_FLOAT; // RULE_06
        if (idx_ext < ELEC_ITEMS) begin
          item.value = vals.elec_flt[item_idx]; // RULE_06
        end
      end
      MOD_MOTOR: begin
        item.value = vals.motor_u32[item_idx]; // RULE_07
      end
      MOD_MAINT: begin
        if (idx_ext < MAINT_ITEMS) begin
          item.value = vals.maint_u32[item_idx]; // RULE_08
        end
      end
      MOD_AUX: begin
        if (idx_ext < AUX_ITEMS) begin
          item.value = vals.aux_u32[item_idx[1:0]]; // RULE_09
        end
      end
      MOD_THERM: begin
        if (idx_ext < THERM_INT_ITEMS) begin
          item.kind = KIND_INT16; // RULE_10
          item.value = {16'h0000, vals.therm_i16[item_idx[1:0]]};
        end else begin
          item.kind = KIND_FLOAT; // RULE_10
          item.value = vals.thermal_capacity_used;
        end
      end
      default: begin
        item.value = 32'h0000_0000;
      end
    endcase
  end

endmodule : fbvp_item_map
`default_nettype wire

// [fbvp_packer.sv]
// What this block does
// RULE_01 - Serial frame float bytes go bits 15-8, 7-0, 31-24, 23-16.
// RULE_02 - Integers: high byte first within a word, low word first.
// RULE_03 - Fieldbus cyclic frame sends every variable big endian.
// RULE_04 - Floats are single precision: sign 31, exponent 30-23 biased 127, mantissa 22-0.
// RULE_05 - Unsigned double integers take 32 bits in two 16-bit words.
// RULE_06 - Electrical extension module: six floats, frequency through distortion 3-1.
// RULE_07 - Running motor module: eight 32-bit entries in the given order.
// RULE_08 - Maintenance module: seven 32-bit counters in the given order.
// RULE_09 - Auxiliary module: counter one, counter two, timer one, timer two.
// RULE_10 - Thermal module: three signed 16-bit words then capacity used float.
// RULE_11 - Outside party reaches values by serial function codes or fieldbus slot/index.
// RULE_12 - All words of a frame come from one consistent value update.
`timescale 1ns/10ps
`default_nettype none
module fbvp_packer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Measured values from the protection core
  input wire fbvp_pkg::fbvp_values_s vals,
  input wire logic vals_update,
  // Frame request
  input wire logic req_valid,
  output logic req_ready,
  input wire fbvp_pkg::fbvp_req_s req,
  // Byte stream towards the link
  output logic out_valid,
  input wire logic out_ready,
  output fbvp_pkg::fbvp_byte_s out_byte,
  // Status
  output logic busy,
  output logic req_error,
  output logic float_special,
  output logic vals_pending,
  output logic [15:0] frame_count
);
  import fbvp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic {ST_IDLE, ST_SEND} fbvp_fsm_e;

  typedef struct packed {
    fbvp_fsm_e fsm;
    fbvp_values_s shadow;
    fbvp_values_s snap;
    logic fresh;
    fbvp_req_s cur;
    logic [ITEM_IDX_W-1:0] item;
    logic [LANE_IDX_W-1:0] lane;
    fbvp_byte_s obyte;
    logic ovalid;
    logic err;
    logic fspec;
    logic [15:0] frames;
  } fbvp_state_s;

  fbvp_state_s s_r;
  fbvp_state_s s_nxt;
  fbvp_item_s item;
  logic [7:0] lane_byte;
  logic last_lane;
  logic [3:0] cur_count;
  logic slot_free;
  logic last_item;

  ////////////////////////////////////////////////////////////////////////////
  // Item lookup and byte ordering on the frozen snapshot
  fbvp_item_map u_map (
    .vals(s_r.snap),
    .mod_sel(s_r.cur.mod_sel),
    .item_idx(s_r.item),
    .item(item)
  );

  fbvp_byte_sel u_sel (
    .item(item),
    .fmt(s_r.cur.fmt),
    .lane(s_r.lane),
    .byte_out(lane_byte),
    .last_lane(last_lane)
  );

  // Frame progress terms
  assign cur_count = fbvp_item_count(s_r.cur.mod_sel);
  assign slot_free = !s_r.ovalid || out_ready;
  assign last_item = ({1'b0, s_r.item} == (cur_count - 4'h1));

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.err = 1'b0;
    // Each update replaces the whole shadow at once
    if (vals_update) begin
      s_nxt.shadow = vals; // RULE_12
      s_nxt.fresh = 1'b1;
    end
    // Output byte leaves when the link takes it
    if (s_r.ovalid && out_ready) begin
      s_nxt.ovalid = 1'b0;
    end
    case (s_r.fsm)
      ST_IDLE: begin
        if (req_valid) begin
          // Request format picks serial or fieldbus ordering
          if (fbvp_item_count(req.mod_sel) == 4'h0) begin
            s_nxt.err = 1'b1;
          end else begin
            s_nxt.cur = req; // RULE_11
            s_nxt.item = '0;
            s_nxt.lane = '0;
            s_nxt.fspec = 1'b0;
            // Freeze one consistent set for the whole frame
            s_nxt.snap = vals_update ? vals : s_r.shadow; // RULE_12
            s_nxt.fresh = 1'b0;
            s_nxt.fsm = ST_SEND;
          end
        end
      end
      ST_SEND: begin
        if (slot_free) begin
          s_nxt.obyte.data = lane_byte;
          s_nxt.obyte.first = (s_r.item == '0) && (s_r.lane == '0);
          s_nxt.obyte.last = last_lane && last_item;
          s_nxt.ovalid = 1'b1;
          // Exponent all ones flags a value outside the finite range
          if (item.kind == KIND_FLOAT && s_r.lane == '0 && fbvp_flt_special(item.value)) begin
            s_nxt.fspec = 1'b1; // RULE_04
          end
          if (last_lane) begin
            s_nxt.lane = '0;
            s_nxt.item = s_r.item + 3'h1;
            if (last_item) begin
              s_nxt.item = '0;
              s_nxt.frames = s_r.frames + 16'h0001;
              s_nxt.fsm = ST_IDLE;
            end
          end else begin
            s_nxt.lane = s_r.lane + 2'h1;
          end
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.fsm <= ST_IDLE;
      s_r.frames <= FRAME_COUNT_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready = (s_r.fsm == ST_IDLE);
  assign out_valid = s_r.ovalid;
  assign out_byte = s_r.obyte;
  assign busy = (s_r.fsm == ST_SEND) || s_r.ovalid;
  assign req_error = s_r.err;
  assign float_special = s_r.fspec;
  assign vals_pending = s_r.fresh;
  assign frame_count = s_r.frames;

endmodule : fbvp_packer
`default_nettype wire

// [fbvp_packer_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module fbvp_packer_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports
  input wire logic vals_update,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire fbvp_pkg::fbvp_req_s req,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire fbvp_pkg::fbvp_byte_s out_byte,
  input wire logic busy,
  input wire logic req_error,
  input wire logic vals_pending,
  input wire logic [15:0] frame_count
);
  import fbvp_pkg::*;
  logic take;
  assign take = req_valid && req_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_req_busy: assert property (take && req.mod_sel <= MOD_THERM |=> busy && !req_ready)
    else $error("request not taken");
  a_first_byte: assert property (take && req.mod_sel <= MOD_THERM && !out_valid |-> ##2 out_valid && out_byte.first)
    else $error("first byte late");
  a_bad_code: assert property (take && req.mod_sel > MOD_THERM |=> req_error && req_ready && !busy)
    else $error("bad code not refused");
  a_err_pulse: assert property (req_error |=> !req_error)
    else $error("error pulse too long");
  a_byte_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte dropped in stall");
  a_pend_set: assert property (vals_update && !take |=> vals_pending)
    else $error("pending not set");
  // The count steps at the edge that loads the last byte, before the link takes it
  a_count_step: assert property ($rose(out_valid && out_byte.last) |-> frame_count == $past(frame_count) + 16'h1)
    else $error("frame count wrong");
  a_idle_quiet: assert property (!busy && !req_valid |=> !out_valid)
    else $error("byte while idle");
  // Main scenarios
  c_big: cover property (take && req.fmt == FMT_BIG);
  c_stall: cover property (out_valid && !out_ready);
  c_err: cover property (req_error);
endmodule : fbvp_packer_sva
`default_nettype wire

// [fbvp_packer_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module fbvp_packer_tb;
  import fbvp_pkg::*;
  localparam int NB[5] = '{24, 32, 28, 16, 10};
  logic clk_sys, rst, vals_update, req_valid, req_ready, out_valid, out_ready, stall;
  logic busy, req_error, float_special, vals_pending;
  logic [15:0] frame_count;
  fbvp_values_s vals, ref_v, old_v;
  fbvp_req_s req;
  fbvp_byte_s out_byte;
  fbvp_byte_s got[$];
  int n_errors, checks, exp_fc;
  fbvp_packer dut (.clk_sys(clk_sys), .rst(rst), .vals(vals), .vals_update(vals_update),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .out_valid(out_valid), .out_ready(out_ready),
    .out_byte(out_byte), .busy(busy), .req_error(req_error), .float_special(float_special),
    .vals_pending(vals_pending), .frame_count(frame_count));
  fbvp_sink sink (.clk_sys(clk_sys), .rst(rst), .stall(stall), .out_valid(out_valid), .out_ready(out_ready));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // Expected byte n of a frame of module m
  function automatic logic [7:0] exp_byte(fbvp_values_s v, int m, int n, fbvp_fmt_e f);
    logic [31:0] w;
    int i, l;
    i = (m == 4) ? 3 : n / 4;
    l = (m == 4) ? n - 6 : n % 4;
    case (m)
      0: w = v.elec_flt[i];
      1: w = v.motor_u32[i];
      2: w = v.maint_u32[i];
      3: w = v.aux_u32[i];
      default: w = v.thermal_capacity_used;
    endcase
    if (f == FMT_SERIAL) l = (l + 2) % 4;
    if (m == 4 && n < 6) begin
      w = {16'h0, v.therm_i16[n / 2]};
      l = 2 + n % 2;
    end
    return w[31 - 8 * l -: 8];
  endfunction : exp_byte
  // Taken bytes
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_byte);
  end
  task load(input fbvp_values_s v);
    @(posedge clk_sys);
    vals <= v;
    vals_update <= 1'b1;
    @(posedge clk_sys);
    vals_update <= 1'b0;
  endtask : load
  task frame(input fbvp_mod_e m, input fbvp_fmt_e f, input fbvp_values_s ev);
    int k;
    got.delete();
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{mod_sel: m, fmt: f};
    // Look at ready only where it has settled, never in the launching time step
    for (k = 0; k < 100; k++) begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    for (k = 0; k < 400 && got.size() < NB[m]; k++) @(negedge clk_sys);
    exp_fc++;
    chk(NB[m], got.size());
    foreach (got[j]) begin
      chk(exp_byte(ev, m, j, f), got[j].data);
      chk(j == 0, got[j].first);
      chk(j == NB[m] - 1, got[j].last);
    end
    chk(exp_fc, frame_count);
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(5'h10, {req_ready, out_valid, busy, req_error, vals_pending});
    chk(0, {float_special, out_byte});
    chk(0, frame_count);
  endtask : t_reset
  task t_all;
    for (int m = 0; m < 5; m++) begin
      for (int f = 0; f < 2; f++) frame(fbvp_mod_e'(m), fbvp_fmt_e'(f), ref_v);
    end
  endtask : t_all
  task t_stall;
    stall <= 1'b1;
    frame(MOD_MOTOR, FMT_SERIAL, ref_v);
    frame(MOD_THERM, FMT_BIG, ref_v);
    stall <= 1'b0;
  endtask : t_stall
  task t_bad;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{mod_sel: fbvp_mod_e'(3'h7), fmt: FMT_SERIAL};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    chk(3'h6, {req_error, req_ready, busy});
    @(negedge clk_sys);
    chk(0, req_error);
    chk(exp_fc, frame_count);
  endtask : t_bad
  task t_snap;
    old_v = ref_v;
    ref_v = ~ref_v;
    ref_v.elec_flt[2] = 32'h7f80_0000;
    fork
      frame(MOD_AUX, FMT_BIG, old_v);
      begin
        repeat (5) @(posedge clk_sys);
        load(ref_v);
      end
    join
    chk(1, vals_pending);
    frame(MOD_ELEC, FMT_SERIAL, ref_v);
    chk(2'h2, {float_special, vals_pending});
  endtask : t_snap
  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #1_000_000;
    n_errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {vals_update, req_valid, stall} = 3'h0;
    vals = '0;
    req = '0;
    for (int i = 0; i < 110; i++) ref_v[i * 8 +: 8] = 8'(i * 7 + 3);
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    t_reset();
    load(ref_v);
    t_all();
    t_stall();
    t_bad();
    t_snap();
    summarize();
  end
endmodule : fbvp_packer_tb
bind fbvp_packer fbvp_packer_sva u_sva (.clk_sys(clk_sys), .rst(rst), .vals_update(vals_update),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .out_valid(out_valid), .out_ready(out_ready),
  .out_byte(out_byte), .busy(busy), .req_error(req_error), .vals_pending(vals_pending),
  .frame_count(frame_count));
`default_nettype wire

// [fbvp_pkg.sv]
`default_nettype none
package fbvp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Item counts of each cyclic input module
  localparam logic [3:0] ELEC_ITEMS = 4'h6;
  localparam logic [3:0] MOTOR_ITEMS = 4'h8;
  localparam logic [3:0] MAINT_ITEMS = 4'h7;
  localparam logic [3:0] AUX_ITEMS = 4'h4;
  localparam logic [3:0] THERM_INT_ITEMS = 4'h3;
  localparam logic [3:0] THERM_ITEMS = 4'h4;
  localparam int ITEM_IDX_W = 3;
  localparam int LANE_IDX_W = 2;

  // Index of the last byte lane of one item on the wire
  localparam logic [LANE_IDX_W-1:0] LAST_LANE_WORD = 2'h1;
  localparam logic [LANE_IDX_W-1:0] LAST_LANE_DWORD = 2'h3;

  // Single-precision field positions and bias
  localparam int FLT_SIGN_POS = 31;
  localparam int FLT_EXP_HI = 30;
  localparam int FLT_EXP_LO = 23;
  localparam int FLT_MAN_HI = 22;
  localparam int FLT_EXP_BIAS = 127;
  localparam logic [7:0] FLT_EXP_MAX = 8'hff;

  // Bit position of the low bit of each byte lane
  localparam int LANE3_LO = 24;
  localparam int LANE2_LO = 16;
  localparam int LANE1_LO = 8;
  localparam int LANE0_LO = 0;

  // Reset values
  localparam logic [15:0] FRAME_COUNT_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Frame format: serial register frame or big-endian fieldbus frame
  typedef enum logic {FMT_SERIAL, FMT_BIG} fbvp_fmt_e;

  // Wire type of one item
  typedef enum logic [1:0] {KIND_INT16, KIND_UINT32, KIND_FLOAT} fbvp_kind_e;

  // Cyclic input modules
  typedef enum logic [2:0] {MOD_ELEC, MOD_MOTOR, MOD_MAINT, MOD_AUX, MOD_THERM} fbvp_mod_e;

  // Snapshot of every value the modules carry
  typedef struct packed {
    logic [ELEC_ITEMS-1:0][31:0] elec_flt;
    logic [MOTOR_ITEMS-1:0][31:0] motor_u32;
    logic [MAINT_ITEMS-1:0][31:0] maint_u32;
    logic [AUX_ITEMS-1:0][31:0] aux_u32;
    logic [THERM_INT_ITEMS-1:0][15:0] therm_i16;
    logic [31:0] thermal_capacity_used;
  } fbvp_values_s;

  typedef struct packed {
    fbvp_kind_e kind;
    logic [31:0] value;
  } fbvp_item_s;

  typedef struct packed {
    fbvp_mod_e mod_sel;
    fbvp_fmt_e fmt;
  } fbvp_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
  } fbvp_byte_s;

  ////////////////////////////////////////////////////////////////////////////
  // Number of items in a module, zero for an unknown code
  function automatic logic [3:0] fbvp_item_count(input fbvp_mod_e m);
    case (m)
      MOD_ELEC: fbvp_item_count = ELEC_ITEMS;
      MOD_MOTOR: fbvp_item_count = MOTOR_ITEMS;
      MOD_MAINT: fbvp_item_count = MAINT_ITEMS;
      MOD_AUX: fbvp_item_count = AUX_ITEMS;
      MOD_THERM: fbvp_item_count = THERM_ITEMS;
      default: fbvp_item_count = 4'h0;
    endcase
  endfunction : fbvp_item_count

  // One byte lane of a 32-bit value
  function automatic logic [7:0] fbvp_lane(input logic [31:0] v, input int lo);
    fbvp_lane = v[lo +: 8];
  endfunction : fbvp_lane

  // True when the exponent field is all ones (infinity or not a number)
  function automatic logic fbvp_flt_special(input logic [31:0] v);
    fbvp_flt_special = (v[FLT_EXP_HI:FLT_EXP_LO] == FLT_EXP_MAX);
  endfunction : fbvp_flt_special

endpackage : fbvp_pkg
`default_nettype wire

// [fbvp_sink.sv]
`timescale 1ns/10ps
`default_nettype none
module fbvp_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Stream from the packer
  input wire logic stall,
  input wire logic out_valid,
  output var logic out_ready
);
  // Take every byte, or toggle ready while a byte waits when stalling
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall ? (out_valid ? ~out_ready : out_ready) : 1'b1;
    end
  end
endmodule : fbvp_sink
`default_nettype wire
